// [flash_host_pkg.sv]
// Package of constants for the flash command host controller
package flash_host_pkg;
  // ==========================================================
  // Register map (AXI4-Lite byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] ADDR_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF = 8'h08;
  localparam logic [7:0] STAT_OFF = 8'h0c;
  localparam logic [7:0] RDAT_OFF = 8'h10;
  // CTRL fields: [3:0] op, [4] byte mode, [5] accelerate, [6] hw reset
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BYTE_BIT = 4;
  localparam int CTRL_ACC_BIT = 5;
  localparam int CTRL_HWRST_BIT = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // STAT fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BYPASS_BIT = 1;
  localparam int STAT_RDY_BIT = 2;
  // ==========================================================
  // Operations that software may start
  typedef enum logic [3:0] {
    OP_NONE, OP_RESET, OP_QUERY, OP_PROGRAM, OP_BYPASS_ENTER, OP_BYPASS_PROG,
    OP_BYPASS_EXIT, OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SECTOR_ADD, OP_READ
  } op_t;
  // ==========================================================
  // Command codes and unlock addresses (word mode / byte mode)
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_QUERY = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [11:0] UNLOCK_A1_WORD = 12'h555;
  localparam logic [11:0] UNLOCK_A2_WORD = 12'h2aa;
  localparam logic [11:0] UNLOCK_A1_BYTE = 12'haaa;
  localparam logic [11:0] UNLOCK_A2_BYTE = 12'h555;
  // ==========================================================
  // Bus widths and timing
  localparam int FADDR_W = 21;
  localparam int FDATA_W = 16;
  localparam int CLK_MHZ = 125;
  localparam int PHASE_NS = 40;
  localparam int PHASE_CYC = (PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int SEC_WIN_US = 50;
  localparam int SEC_WIN_CYC = SEC_WIN_US * CLK_MHZ;
endpackage : flash_host_pkg

// [flash_bus_cycle.sv]
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request
  input wire logic start,
  input wire logic is_read,
  input wire logic [FADDR_W-1:0] addr,
  input wire logic [FDATA_W-1:0] wdata,
  output logic done,
  output logic [FDATA_W-1:0] rdata_q,
  // Flash pins
  output logic chip_sel_n_q,
  output logic wr_n_q,
  output logic rd_n_q,
  output logic [FADDR_W-1:0] faddr_q,
  output logic [FDATA_W-1:0] fdq_o_q,
  output logic fdq_oe_q,
  input wire logic [FDATA_W-1:0] fdq_sync
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cyc_t;
  cyc_t st_q;
  logic [7:0] cnt_q;
  logic tick;
  assign tick = (cnt_q == 8'(PHASE_CYC - 1));
  assign done = (st_q == C_HOLD) && tick;
  // ==========================================================
  // Phase sequencer: address set up, strobe low, strobe high and hold.
  // Strobes fall together after the address is stable, so the device's
  // later falling edge sees a settled address and data are stable at rise.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= C_IDLE;
      cnt_q <= 8'h00;
      chip_sel_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      faddr_q <= '0;
      fdq_o_q <= '0;
      fdq_oe_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      cnt_q <= (st_q == C_IDLE || tick) ? 8'h00 : cnt_q + 8'h01;
      case (st_q)
        C_IDLE: if (start) begin
          st_q <= C_SETUP;
          faddr_q <= addr;
          fdq_o_q <= wdata;
          fdq_oe_q <= !is_read;
        end
        C_SETUP: if (tick) begin
          st_q <= C_STROBE;
          chip_sel_n_q <= 1'b0;
          wr_n_q <= is_read;
          rd_n_q <= !is_read;
        end
        C_STROBE: if (tick) begin
          st_q <= C_HOLD;
          rdata_q <= fdq_sync;
          chip_sel_n_q <= 1'b1;
          wr_n_q <= 1'b1;
          rd_n_q <= 1'b1;
        end
        C_HOLD: if (tick) begin
          st_q <= C_IDLE;
          fdq_oe_q <= 1'b0;
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end
endmodule : flash_bus_cycle

// [flash_cmd_host.sv]
// Host controller issuing flash command sequences from AXI4-Lite registers
// What this block does
// - Host writes reset to leave ID query mode.
// - Query: two unlocks then bank address with command 90h.
// - Host does not check whether the other bank programs or erases before a query.
// - Program is two unlocks, A0h, then address and data.
// - Two unlocks plus 20h enter bypass; then A0h plus address/data.
// - In bypass only bypass program and bypass reset are accepted; the host does not block other ops while bypass_q is set.
// - Chip erase: two unlocks, 80h, two unlocks, 10h.
// - Sector erase ends with sector address and 30h.
// - Extra sector addresses must follow within 50 us of the last.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module flash_cmd_host
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash pins
  output logic chip_sel_n,
  output logic wr_n,
  output logic rd_n,
  output logic byte_mode_n,
  output logic hw_reset_n,
  output logic protect_accelerate_pin,
  output logic [FADDR_W-1:0] flash_addr,
  output logic [FDATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [FDATA_W-1:0] flash_dq_i,
  input wire logic ready_busy_output
);
  // ==========================================================
  // Registers
  logic [31:0] ctrl_q, addr_q, data_q;
  logic [FDATA_W-1:0] rdat_q;
  logic go_q, busy_q, bypass_q;
  logic [FDATA_W-1:0] dq_m_q, dq_s_q;
  logic rb_m_q, rb_s_q;
  op_t op;
  assign op = op_t'(ctrl_q[CTRL_OP_LSB +: 4]);
  logic byte_mode;
  assign byte_mode = ctrl_q[CTRL_BYTE_BIT];

  // ==========================================================
  // Pin input synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_m_q <= '0;
      dq_s_q <= '0;
      rb_m_q <= 1'b1;
      rb_s_q <= 1'b1;
    end else begin
      dq_m_q <= flash_dq_i;
      dq_s_q <= dq_m_q;
      rb_m_q <= ready_busy_output;
      rb_s_q <= rb_m_q;
    end
  end

  // ==========================================================
  // AXI4-Lite write side: address and data taken in either order
  logic aw_have_q, w_have_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic wr_fire;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q;
  assign s_axi_bresp = 2'b00;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; a CTRL write with a nonzero op starts a sequence.
  // Writes while busy or with an order pending are dropped and start no new sequence.
  logic seq_done, drop_go;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      addr_q <= 32'h0;
      data_q <= 32'h0;
      go_q <= 1'b0;
    end else begin
      if (seq_done || drop_go) go_q <= 1'b0;
      if (wr_fire && w_q != 32'h0 && aw_q == CTRL_OFF && !busy_q && !go_q) go_q <= 1'b1;
      if (wr_fire && !(busy_q || go_q)) begin
        if (aw_q == CTRL_OFF) ctrl_q <= w_q;
        if (aw_q == ADDR_OFF) addr_q <= w_q;
        if (aw_q == DATA_OFF) data_q <= w_q;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read side, one cycle answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        CTRL_OFF: s_axi_rdata <= ctrl_q;
        ADDR_OFF: s_axi_rdata <= addr_q;
        DATA_OFF: s_axi_rdata <= data_q;
        STAT_OFF: s_axi_rdata <= {29'h0, rb_s_q, bypass_q, busy_q | go_q};
        RDAT_OFF: s_axi_rdata <= {16'h0, rdat_q};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;

  // ==========================================================
  // Sequence engine: steps through the cycles of one command sequence
  logic [2:0] step_q;
  logic [2:0] n_steps;
  logic cyc_start, cyc_done, cyc_read;
  logic [FADDR_W-1:0] cyc_addr;
  logic [FDATA_W-1:0] cyc_data, cyc_rdata;
  logic [11:0] u1, u2;
  assign u1 = byte_mode ? UNLOCK_A1_BYTE : UNLOCK_A1_WORD;
  assign u2 = byte_mode ? UNLOCK_A2_BYTE : UNLOCK_A2_WORD;
  logic [FADDR_W-1:0] bank_u1;
  assign bank_u1 = {addr_q[FADDR_W-1:12], u1}; // Bank address in upper bits

  // Length of each sequence in bus cycles
  always_comb begin
    case (op)
      OP_RESET, OP_SECTOR_ADD, OP_READ: n_steps = 3'd1;
      OP_QUERY, OP_BYPASS_ENTER: n_steps = 3'd3;
      OP_PROGRAM: n_steps = 3'd4;
      OP_BYPASS_PROG, OP_BYPASS_EXIT: n_steps = 3'd2;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: n_steps = 3'd6;
      default: n_steps = 3'd0;
    endcase
  end

  // Address and data of the current step
  always_comb begin
    cyc_read = (op == OP_READ);
    cyc_addr = addr_q[FADDR_W-1:0];
    cyc_data = data_q[FDATA_W-1:0];
    case (op)
      OP_RESET: cyc_data = {8'h00, CMD_RESET};
      OP_BYPASS_PROG: if (step_q == 3'd0) cyc_data = {8'h00, CMD_PROGRAM};
      OP_BYPASS_EXIT: cyc_data = (step_q == 3'd0) ? {8'h00, CMD_QUERY}
                                                  : {8'h00, CMD_BYPASS_EXIT2};
      OP_SECTOR_ADD: cyc_data = {8'h00, CMD_SECTOR_ERASE};
      OP_READ: cyc_data = '0;
      default: begin
        case (step_q)
          3'd0, 3'd3: if (op != OP_PROGRAM || step_q == 3'd0) begin
            cyc_addr = {9'h0, u1};
            cyc_data = {8'h00, CMD_UNLOCK1};
          end
          3'd1, 3'd4: begin
            cyc_addr = {9'h0, u2};
            cyc_data = {8'h00, CMD_UNLOCK2};
          end
          3'd2: begin
            cyc_addr = bank_u1;
            case (op)
              OP_QUERY: cyc_data = {8'h00, CMD_QUERY};
              OP_PROGRAM: cyc_data = {8'h00, CMD_PROGRAM};
              OP_BYPASS_ENTER: cyc_data = {8'h00, CMD_BYPASS};
              default: cyc_data = {8'h00, CMD_ERASE_SETUP};
            endcase
          end
          default: begin
            // Last cycle of an erase: the erase command; program address/data come at step 3
            if (op == OP_CHIP_ERASE) begin
              cyc_addr = {9'h0, u1};
              cyc_data = {8'h00, CMD_CHIP_ERASE};
            end else if (op == OP_SECTOR_ERASE) begin
              cyc_data = {8'h00, CMD_SECTOR_ERASE};
            end
          end
        endcase
      end
    endcase
  end

  // Step counter and busy; a sector address is refused once the window lapses
  logic [15:0] win_q;
  logic win_open;
  assign win_open = (win_q != 16'h0);
  logic refuse;
  assign refuse = (op == OP_SECTOR_ADD) && !win_open;
  // An order that cannot start is dropped, or later register writes would stall
  assign drop_go = go_q && !busy_q && (refuse || n_steps == 3'd0);
  logic cyc_done_q;
  assign cyc_start = busy_q && !cyc_done_q;
  assign seq_done = busy_q && cyc_done && (step_q == n_steps - 3'd1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      step_q <= 3'd0;
      cyc_done_q <= 1'b0;
    end else begin
      cyc_done_q <= cyc_done;
      if (!busy_q && go_q && !refuse && n_steps != 3'd0) begin
        busy_q <= 1'b1;
        step_q <= 3'd0;
      end else if (seq_done) begin
        busy_q <= 1'b0;
      end else if (busy_q && cyc_done) begin
        step_q <= step_q + 3'd1;
      end
    end
  end

  // Sector window timer restarts one hold phase after each sector command's strobe rise, loaded short by PHASE_CYC
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 16'h0;
    end else if (seq_done && (op == OP_SECTOR_ERASE || op == OP_SECTOR_ADD)) begin
      win_q <= 16'(SEC_WIN_CYC - PHASE_CYC);
    end else if (seq_done) begin
      win_q <= 16'h0;
    end else if (win_open) begin
      win_q <= win_q - 16'h1;
    end
  end

  // Bypass state: tracked from bypass enter, bypass exit and reset only, not from accelerate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass_q <= 1'b0;
      rdat_q <= '0;
    end else if (seq_done) begin
      if (op == OP_BYPASS_ENTER) bypass_q <= 1'b1;
      if (op == OP_BYPASS_EXIT || op == OP_RESET) bypass_q <= 1'b0;
      if (op == OP_READ) rdat_q <= cyc_rdata;
    end
  end

  // ==========================================================
  // Static pins
  assign byte_mode_n = !byte_mode;
  assign hw_reset_n = !ctrl_q[CTRL_HWRST_BIT];
  assign protect_accelerate_pin = ctrl_q[CTRL_ACC_BIT];

  flash_bus_cycle u_cycle (
    .clk(clk),
    .rst_n(rst_n),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .done(cyc_done),
    .rdata_q(cyc_rdata),
    .chip_sel_n_q(chip_sel_n),
    .wr_n_q(wr_n),
    .rd_n_q(rd_n),
    .faddr_q(flash_addr),
    .fdq_o_q(flash_dq_o),
    .fdq_oe_q(flash_dq_oe),
    .fdq_sync(dq_s_q)
  );

  // ==========================================================
  // Checks
  a_strobe_pair: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_n |-> !chip_sel_n && flash_dq_oe) else $error("write strobe without select");
  a_data_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_n && $past(!wr_n) |-> $stable(flash_dq_o) && $stable(flash_addr))
    else $error("data moved under strobe");
  a_unlock_first: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(wr_n) && busy_q && step_q == 3'd0 && op == OP_PROGRAM
    |-> flash_dq_o[7:0] == CMD_UNLOCK1) else $error("bad first unlock");
  a_query_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(wr_n) && step_q == 3'd2 && op == OP_QUERY |-> flash_dq_o[7:0] == CMD_QUERY)
    else $error("bad query command");
  a_bypass_two: assert property (@(posedge clk) disable iff (!rst_n)
    busy_q && op == OP_BYPASS_PROG |-> step_q < 3'd2) else $error("bypass too long");
  a_reset_code: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(wr_n) && op == OP_RESET |-> flash_dq_o[7:0] == CMD_RESET)
    else $error("bad reset code");
  a_chip_last: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(wr_n) && step_q == 3'd5 && op == OP_CHIP_ERASE
    |-> flash_dq_o[7:0] == CMD_CHIP_ERASE) else $error("bad chip erase");
  a_window_len: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(win_open) |-> win_q == 16'(SEC_WIN_CYC - PHASE_CYC))
    else $error("bad window");
endmodule : flash_cmd_host

// [flash_dev_model.sv]
// Behavioural flash device answering the host controller's pins
`timescale 1ns/1ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h005a, // Arbitrary value
  parameter int BUSY_CYC = 80
) (
  // Time base
  input wire logic clk,
  // Pins from the host
  input wire logic chip_sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic byte_mode_n,
  input wire logic hw_reset_n,
  input wire logic protect_accelerate_pin,
  input wire logic [FADDR_W-1:0] flash_addr,
  input wire logic [FDATA_W-1:0] flash_dq_o,
  // Pins to the host
  output logic [FDATA_W-1:0] flash_dq_i,
  output logic ready_busy_output
);
  // ==========================================================
  // Bank state
  localparam int M_READ = 0;
  localparam int M_QUERY = 1;
  localparam int M_BYP = 2;
  localparam int M_BUSY = 3;
  localparam int M_WIN = 4;
  int mode = M_READ;
  int step = 0;
  int pend = 0;
  int busy_n = 0;
  int win_n = 0;
  int n_sect = 0;
  bit byp = 0;
  bit era = 0;
  logic [15:0] mem [256];
  logic [7:0] prog_a;
  logic [15:0] prog_d;
  logic [15:0] last_q = 16'h0000;
  logic [15:0] rd_v;
  logic [11:0] ca;
  logic [7:0] cd;
  logic [11:0] a1;
  logic [11:0] a2;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign a1 = byte_mode_n ? UNLOCK_A1_WORD : UNLOCK_A1_BYTE;
  assign a2 = byte_mode_n ? UNLOCK_A2_WORD : UNLOCK_A2_BYTE;
  assign ready_busy_output = (mode != M_BUSY);
  // ==========================================================
  // Address on the strobe fall, command data on its rise
  always @(negedge wr_n) ca = flash_addr[11:0];
  always @(posedge wr_n) begin
    cd = flash_dq_o[7:0];
    if (mode == M_BUSY || !hw_reset_n) begin
      cd = cd; // Embedded work ignores every command
    end else if (mode == M_WIN) begin
      if (cd == CMD_SECTOR_ERASE) begin
        n_sect++;
        win_n = SEC_WIN_CYC;
      end else mode = M_READ;
    end else if (pend == 1) begin
      prog_a = flash_addr[7:0];
      prog_d = flash_dq_o;
      era = 0;
      pend = 0;
      mode = M_BUSY;
      busy_n = BUSY_CYC;
    end else if (mode == M_BYP) begin
      if (pend == 3 && cd == CMD_BYPASS_EXIT2) begin
        mode = M_READ;
        byp = 0;
      end
      pend = (cd == CMD_PROGRAM) ? 1 : (cd == CMD_QUERY) ? 3 : 0;
    end else if (cd == CMD_RESET) begin
      mode = M_READ;
      step = 0;
      pend = 0;
    end else if (step == 0 || step == 3) step = (cd == CMD_UNLOCK1 && ca == a1) ? step + 1 : 0;
    else if (step == 1 || step == 4) step = (cd == CMD_UNLOCK2 && ca == a2) ? step + 1 : 0;
    else if (step == 2) begin
      step = (cd == CMD_ERASE_SETUP) ? 3 : 0;
      if (cd == CMD_QUERY) mode = M_QUERY;
      if (cd == CMD_PROGRAM) pend = 1;
      if (cd == CMD_BYPASS) mode = M_BYP;
      byp = (cd == CMD_BYPASS);
    end else begin
      step = 0;
      era = 1;
      if (cd == CMD_CHIP_ERASE) begin
        mode = M_BUSY;
        busy_n = BUSY_CYC;
      end else if (cd == CMD_SECTOR_ERASE) begin
        mode = M_WIN;
        win_n = SEC_WIN_CYC;
        n_sect = 1;
      end
    end
  end
  // ==========================================================
  // Timed work; hardware reset cuts it short at once
  always @(posedge clk) begin
    if (!hw_reset_n) begin
      mode = M_READ;
      busy_n = 0;
      win_n = 0;
    end else if (mode == M_WIN && win_n > 0) begin
      win_n--;
      if (win_n == 0) mode = M_BUSY;
      busy_n = BUSY_CYC;
    end else if (mode == M_BUSY && --busy_n <= 0) begin
      if (era) foreach (mem[i]) mem[i] = 16'hffff;
      else mem[prog_a] = mem[prog_a] & prog_d;
      mode = byp ? M_BYP : M_READ;
    end
  end
  // High voltage on the protect pin forces bypass
  always @(posedge protect_accelerate_pin) begin
    byp = 1;
    if (mode == M_READ) mode = M_BYP;
  end
  // Dropping the high voltage leaves the forced bypass altogether
  always @(negedge protect_accelerate_pin) begin
    byp = 0;
    if (mode == M_BYP) mode = M_READ;
  end
  // ==========================================================
  // Read data; a released bus shows the inverse of the last value
  always @* begin
    if (mode == M_QUERY && flash_addr[7:0] == 8'h00) rd_v = MAKER_CODE;
    else if (mode == M_QUERY && flash_addr[7:0] == (byte_mode_n ? 8'h01 : 8'h02)) rd_v = DEVICE_CODE;
    else if (mode == M_QUERY) rd_v = 16'h0001;
    else if (mode == M_BUSY) rd_v = 16'h0000;
    else rd_v = mem[flash_addr[7:0]];
  end
  always @(posedge rd_n) last_q = rd_v;
  assign flash_dq_i = (!chip_sel_n && !rd_n) ? rd_v : ~last_q;
endmodule : flash_dev_model

// [tb_top.sv]
// Testbench for the flash command host against the device model
`timescale 1ns/1ps
module tb_top;
  import flash_host_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic cs_n, we_n, oe_n, bm_n, hr_n, acc, dq_oe, rb;
  logic [FADDR_W-1:0] fa;
  logic [FDATA_W-1:0] dqo, dqi;
  logic [31:0] v;
  int failures = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  flash_cmd_host dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_sel_n(cs_n),
    .wr_n(we_n), .rd_n(oe_n), .byte_mode_n(bm_n), .hw_reset_n(hr_n),
    .protect_accelerate_pin(acc), .flash_addr(fa), .flash_dq_o(dqo), .flash_dq_oe(dq_oe),
    .flash_dq_i(dqi), .ready_busy_output(rb));
  flash_dev_model dev (.clk(clk), .chip_sel_n(cs_n), .wr_n(we_n), .rd_n(oe_n),
    .byte_mode_n(bm_n), .hw_reset_n(hr_n), .protect_accelerate_pin(acc), .flash_addr(fa),
    .flash_dq_o(dqo), .flash_dq_i(dqi), .ready_busy_output(rb));
  // ==========================================================
  // Reporting
  task automatic conclude;
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hang;
    chk("handshake", 32'h1, 32'h0);
    conclude();
  endtask : hang
  // ==========================================================
  // AXI4-Lite master cycles; every wait is bounded
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) hang();
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rready <= 1'b0;
    if (n == 50) hang();
  endtask : axr
  // Poll one STAT bit until it reads the wanted level
  task automatic idle(input int b, input logic lv);
    logic [31:0] s;
    int n;
    for (n = 0; n < 3000; n++) begin
      axr(STAT_OFF, s);
      if (s[b] === lv) break;
    end
    if (n == 3000) hang();
  endtask : idle
  task automatic op(input op_t o, input logic [31:0] a, input logic [31:0] d);
    axw(ADDR_OFF, a);
    axw(DATA_OFF, d);
    axw(CTRL_OFF, {28'h0, o});
    idle(STAT_BUSY_BIT, 1'b0);
  endtask : op
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    op(OP_READ, a, 32'h0);
    axr(RDAT_OFF, d);
  endtask : rd
  // ==========================================================
  // Scenarios
  task automatic t_query;
    op(OP_QUERY, 32'h1000, 32'h0);
    rd(32'h1000, v);
    chk("maker", 32'h00a5, v);
    rd(32'h1001, v);
    chk("device", 32'h005a, v);
    rd(32'h1002, v);
    chk("protect", 32'h0001, v);
    op(OP_RESET, 32'h1fff, 32'h0);
    rd(32'h1002, v);
    chk("array", 32'hffff, v);
  endtask : t_query
  task automatic t_program;
    op(OP_PROGRAM, 32'h5, 32'h00f0);
    idle(STAT_RDY_BIT, 1'b1);
    rd(32'h5, v);
    chk("prog", 32'h00f0, v);
    op(OP_PROGRAM, 32'h5, 32'hff0f);
    idle(STAT_RDY_BIT, 1'b1);
    rd(32'h5, v);
    chk("zero_kept", 32'h0000, v);
    op(OP_PROGRAM, 32'h8, 32'h0);
    op(OP_RESET, 32'h0, 32'h0);
    idle(STAT_RDY_BIT, 1'b1);
    rd(32'h8, v);
    chk("reset_ignored", 32'h0000, v);
    op(OP_PROGRAM, 32'h6, 32'h0);
    axw(CTRL_OFF, 32'h1 << CTRL_HWRST_BIT);
    axw(CTRL_OFF, 32'h0);
    idle(STAT_RDY_BIT, 1'b1);
    rd(32'h6, v);
    chk("hw_abort", 32'hffff, v);
  endtask : t_program
  task automatic t_bypass;
    op(OP_BYPASS_ENTER, 32'h0, 32'h0);
    chk("bypass_in", 32'd2, dev.mode);
    axr(STAT_OFF, v);
    chk("stat_bypass", 32'h1, {31'h0, v[STAT_BYPASS_BIT]});
    op(OP_BYPASS_PROG, 32'h9, 32'h1234);
    idle(STAT_RDY_BIT, 1'b1);
    rd(32'h9, v);
    chk("byp_prog", 32'h1234, v);
    op(OP_BYPASS_EXIT, 32'h0, 32'h0);
    chk("bypass_out", 32'd0, dev.mode);
    axw(CTRL_OFF, 32'h1 << CTRL_ACC_BIT);
    chk("acc_bypass", 32'd2, dev.mode);
    axw(CTRL_OFF, 32'h0);
  endtask : t_bypass
  task automatic t_erase;
    op(OP_CHIP_ERASE, 32'h0, 32'h0);
    idle(STAT_RDY_BIT, 1'b0);
    idle(STAT_RDY_BIT, 1'b1);
    rd(32'h5, v);
    chk("chip_erase", 32'hffff, v);
    op(OP_PROGRAM, 32'h9, 32'h0);
    idle(STAT_RDY_BIT, 1'b1);
    op(OP_SECTOR_ERASE, 32'h3000, 32'h0);
    op(OP_RESET, 32'h0, 32'h0);
    chk("win_abandon", 32'd0, dev.mode);
    op(OP_SECTOR_ERASE, 32'h3000, 32'h0);
    op(OP_SECTOR_ADD, 32'h4000, 32'h0);
    chk("sectors", 32'd2, dev.n_sect);
    idle(STAT_RDY_BIT, 1'b0);
    idle(STAT_RDY_BIT, 1'b1);
    rd(32'h9, v);
    chk("sect_erase", 32'hffff, v);
  endtask : t_erase
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_query();
    t_program();
    t_bypass();
    t_erase();
    conclude();
  end
endmodule : tb_top
